// ===== hdl/servo_channel_shaping.sv
// Per-servo reverse, offset, travel and clamp with supplementary-control assignment
`timescale 1ns/100ps
`include "servo_channel_shaping_map.svh"
module servo_channel_shaping
   import servo_shaping_pkg::*;
#(
   parameter int NUM_SERVOS = 6
)
(
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic signed [15:0]   chan_pct [NUM_SERVOS],
   input  wire logic signed [15:0]   rotary_a_pct,
   input  wire logic signed [15:0]   rotary_b_pct,
   input  wire logic        [3:0]    rotary_a_detent,
   input  wire logic        [3:0]    rotary_b_detent,
   input  wire logic        [1:0]    tri_toggle_a,
   input  wire logic        [1:0]    tri_toggle_b,
   input  wire logic                 two_pos_switch,
   input  wire logic                 momentary_switch,
   input  wire logic        [2:0]    cfg_sel,
   input  wire logic                 cfg_rev_wr,
   input  wire logic                 cfg_rev_val,
   input  wire logic                 cfg_rev_clr,
   input  wire logic                 cfg_off_wr,
   input  wire logic signed [7:0]    cfg_off_val,
   input  wire logic                 cfg_off_clr,
   input  wire logic                 cfg_trav_wr,
   input  wire logic                 cfg_trav_side,
   input  wire logic        [7:0]    cfg_trav_val,
   input  wire logic                 cfg_trav_clr,
   input  wire logic                 learn_start,
   input  wire logic                 learn_input,
   input  wire logic                 assign_clr,
   output logic             [15:0]   pulse_us [NUM_SERVOS],
   output logic                      learn_busy,
   output source_t                   assign_five,
   output source_t                   assign_six
);

   initial begin
      if (NUM_SERVOS < 6 || NUM_SERVOS > 8)
         $error("NUM_SERVOS must be 6 to 8");
   end

   logic                     rev_ff    [NUM_SERVOS];
   logic signed [7:0]        off_ff    [NUM_SERVOS];
   logic        [7:0]        trav_lo_ff[NUM_SERVOS];
   logic        [7:0]        trav_hi_ff[NUM_SERVOS];
   source_t                  asg_ff    [2];
   learn_state_t             learn_ff;
   logic                     learn_idx_ff;
   logic        [3:0]        base_a_ff;
   logic        [3:0]        base_b_ff;
   logic signed [15:0]       src_val   [2];

   function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                                input logic signed [15:0] lim);
      if (v > lim)
         clamp = lim;
      else if (v < -lim)
         clamp = -lim;
      else
         clamp = v;
   endfunction

   function automatic logic signed [15:0] tri_pct(input logic [1:0] pos);
      case (pos)
         2'h1:    tri_pct = `ENDPOINT_PCT;
         2'h2:    tri_pct = -`ENDPOINT_PCT;
         default: tri_pct = 16'sh0000;
      endcase
   endfunction

   function automatic logic [3:0] absdiff(input logic [3:0] a, input logic [3:0] b);
      absdiff = (a > b) ? 4'(a - b) : 4'(b - a);
   endfunction

   // Each channel index is a receiver socket; no stick-mode remap
   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < NUM_SERVOS; i++)
      begin
         if (rst || (cfg_rev_clr && cfg_sel == 3'(i)))
            rev_ff[i] <= 1'b0;
         else if (cfg_rev_wr && cfg_sel == 3'(i))
            rev_ff[i] <= cfg_rev_val;
      end
   end

   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < NUM_SERVOS; i++)
      begin
         if (rst || (cfg_off_clr && cfg_sel == 3'(i)))
            off_ff[i] <= `OFFSET_RST_PCT;
         else if (cfg_off_wr && cfg_sel == 3'(i))
            off_ff[i] <= 8'(clamp(16'(cfg_off_val), `OFFSET_MAX_PCT));
      end
   end

   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < NUM_SERVOS; i++)
      begin
         if (rst)
         begin
            trav_lo_ff[i] <= `TRAVEL_RST_PCT;
            trav_hi_ff[i] <= `TRAVEL_RST_PCT;
         end
         else if (cfg_sel == 3'(i) && (cfg_trav_clr || cfg_trav_wr))
         begin
            if (cfg_trav_side)
               trav_hi_ff[i] <= cfg_trav_clr ? `TRAVEL_RST_PCT :
                  ((cfg_trav_val > `TRAVEL_MAX_PCT) ? `TRAVEL_MAX_PCT : cfg_trav_val);
            else
               trav_lo_ff[i] <= cfg_trav_clr ? `TRAVEL_RST_PCT :
                  ((cfg_trav_val > `TRAVEL_MAX_PCT) ? `TRAVEL_MAX_PCT : cfg_trav_val);
         end
      end
   end

   // Assignment learning: switches register at once, rotaries after detents
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         asg_ff[0]    <= src_free;
         asg_ff[1]    <= src_free;
         learn_ff     <= learn_idle;
         learn_idx_ff <= 1'b0;
         base_a_ff    <= 4'h0;
         base_b_ff    <= 4'h0;
      end
      else
      begin
         case (learn_ff)
            learn_idle:
            begin
               if (assign_clr)
                  asg_ff[learn_input] <= src_free;
               else if (learn_start)
               begin
                  learn_ff     <= learn_watch;
                  learn_idx_ff <= learn_input;
                  base_a_ff    <= rotary_a_detent;
                  base_b_ff    <= rotary_b_detent;
               end
            end
            learn_watch:
            begin
               learn_ff <= learn_idle;
               if (assign_clr)
                  asg_ff[learn_idx_ff] <= src_free;
               else if (absdiff(rotary_a_detent, base_a_ff) >= `DETENT_STEPS)
                  asg_ff[learn_idx_ff] <= src_rotary_a;
               else if (absdiff(rotary_b_detent, base_b_ff) >= `DETENT_STEPS)
                  asg_ff[learn_idx_ff] <= src_rotary_b;
               else if (tri_toggle_a != 2'h0)
                  asg_ff[learn_idx_ff] <= src_tri_a;
               else if (tri_toggle_b != 2'h0)
                  asg_ff[learn_idx_ff] <= src_tri_b;
               else if (two_pos_switch)
                  asg_ff[learn_idx_ff] <= src_two_pos;
               else if (momentary_switch)
                  asg_ff[learn_idx_ff] <= src_momentary;
               else
                  learn_ff <= learn_watch;
            end
            default: learn_ff <= learn_idle;
         endcase
      end
   end

   assign learn_busy  = (learn_ff == learn_watch);
   assign assign_five = asg_ff[0];
   assign assign_six  = asg_ff[1];

   // Both inputs can read the same physical control independently
   always_comb
   begin
      for (int k = 0; k < 2; k++)
      begin
         case (asg_ff[k])
            src_rotary_a:  src_val[k] = rotary_a_pct;
            src_rotary_b:  src_val[k] = rotary_b_pct;
            src_tri_a:     src_val[k] = tri_pct(tri_toggle_a);
            src_tri_b:     src_val[k] = tri_pct(tri_toggle_b);
            src_two_pos:   src_val[k] = two_pos_switch ? `ENDPOINT_PCT : -`ENDPOINT_PCT;
            src_momentary: src_val[k] = momentary_switch ? `ENDPOINT_PCT : -`ENDPOINT_PCT;
            default:       src_val[k] = 16'sh0000;
         endcase
      end
   end

   // Output stage after all mixing, whatever the source
   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < NUM_SERVOS; i++)
      begin : out_stage
         logic signed [15:0] raw;
         logic signed [31:0] scaled;
         logic signed [15:0] cmd;
         raw = 16'sh0000;
         scaled = 32'sh0;
         cmd = 16'sh0000;
         if (rst)
            pulse_us[i] <= 16'(`NEUTRAL_US);
         else
         begin
            if (i == 4)
               raw = src_val[0];
            else if (i == 5)
               raw = src_val[1];
            else if (i < 4)
               raw = chan_pct[i];
            if (rev_ff[i])
               raw = -raw;
            if (raw < 0)
               scaled = (32'(raw) * $signed({24'h0, trav_lo_ff[i]})) / 32'sd100;
            else
               scaled = (32'(raw) * $signed({24'h0, trav_hi_ff[i]})) / 32'sd100;
            cmd = clamp(16'(scaled) + 16'(off_ff[i]), `CLAMP_PCT);
            pulse_us[i] <= 16'(`NEUTRAL_US + 16'((32'(cmd) * 32'(`US_PER_100PCT)) / 32'sd100));
         end
      end
   end

endmodule // servo_channel_shaping

// ===== hdl/servo_channel_shaping_map.svh
// Constants for the servo channel shaping block
`ifndef SERVO_CHANNEL_SHAPING_MAP_SVH
`define SERVO_CHANNEL_SHAPING_MAP_SVH
`define NEUTRAL_US       16'sd1500
`define US_PER_100PCT    16'sd500
`define OFFSET_MAX_PCT   16'sd125
`define CLAMP_PCT        16'sd150
`define TRAVEL_MAX_PCT   8'd150
`define TRAVEL_RST_PCT   8'd100
`define OFFSET_RST_PCT   8'sd0
`define ENDPOINT_PCT     16'sd100
`define DETENT_STEPS     4'd3
`endif

// ===== hdl/servo_shaping_pkg.sv
// Types for the servo channel shaping block
package servo_shaping_pkg;
   typedef enum logic [2:0] {
      src_free,
      src_rotary_a,
      src_rotary_b,
      src_tri_a,
      src_tri_b,
      src_two_pos,
      src_momentary
   } source_t;
   typedef enum {
      learn_idle,
      learn_watch
   } learn_state_t;
endpackage

// ===== bench/servo_bank_model.sv
// Servo bank that turns pulse widths into signed positions in percent
`timescale 1ns/100ps
module servo_bank_model #(
   parameter int NUM_SERVOS = 6
)
(
   input  wire logic                 core_clk,
   input  wire logic        [15:0]   pulse_us [NUM_SERVOS],
   output logic signed      [15:0]   pos_pct  [NUM_SERVOS]
);
   // Each servo follows its latest pulse, 5 us per percent about 1500 us
   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < NUM_SERVOS; i++)
         pos_pct[i] <= (signed'(pulse_us[i]) - 16'sd1500) / 16'sd5;
   end
endmodule // servo_bank_model

// ===== bench/servo_channel_shaping_sva.sv
// Port checker for the servo channel shaping block
`timescale 1ns/100ps
module servo_channel_shaping_sva
   import servo_shaping_pkg::*;
#(
   parameter int NUM_SERVOS = 6
)
(
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic        [3:0]    rotary_a_detent,
   input  wire logic        [3:0]    rotary_b_detent,
   input  wire logic        [1:0]    tri_toggle_a,
   input  wire logic        [1:0]    tri_toggle_b,
   input  wire logic                 two_pos_switch,
   input  wire logic                 momentary_switch,
   input  wire logic                 learn_start,
   input  wire logic                 assign_clr,
   input  wire logic        [15:0]   pulse_us [NUM_SERVOS],
   input  wire logic                 learn_busy,
   input  wire source_t              assign_five,
   input  wire source_t              assign_six
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   reset_centre_a: assert property ($fell(rst) |-> pulse_us[0] == 16'h05dc)
      else $error("centre pulse wrong after reset");
   clamp_zero_a: assert property (pulse_us[0] >= 16'h02ee && pulse_us[0] <= 16'h08ca)
      else $error("servo 1 outside travel limit");
   clamp_five_a: assert property (pulse_us[4] >= 16'h02ee && pulse_us[4] <= 16'h08ca)
      else $error("servo 5 outside travel limit");
   free_default_a: assert property ($fell(rst) |-> assign_five == src_free && assign_six == src_free)
      else $error("assignment not free after reset");
   learn_enter_a: assert property (learn_start && !learn_busy && !assign_clr |=> learn_busy)
      else $error("learn not entered");
   learn_clear_a: assert property (learn_busy && assign_clr |=> !learn_busy)
      else $error("clear did not end learn");
   hold_assign_a: assert property (!learn_busy && !learn_start && !assign_clr
      |=> $stable(assign_five) && $stable(assign_six))
      else $error("assignment changed outside learn");
   small_move_a: assert property (learn_busy && !assign_clr && tri_toggle_a == 2'h0
      && tri_toggle_b == 2'h0 && !momentary_switch && $stable(rotary_a_detent)
      && $stable(rotary_b_detent) && !two_pos_switch |=> learn_busy)
      else $error("learn ended without a control");
   two_pos_hit_a: assert property (learn_busy && !assign_clr && tri_toggle_a == 2'h0
      && tri_toggle_b == 2'h0 && !momentary_switch && $stable(rotary_a_detent)
      && $stable(rotary_b_detent) && two_pos_switch |=> !learn_busy)
      else $error("two-position switch not taken");
endmodule // servo_channel_shaping_sva
bind servo_channel_shaping servo_channel_shaping_sva #(.NUM_SERVOS(NUM_SERVOS)) u_sva (
   .core_clk(core_clk), .rst(rst), .rotary_a_detent(rotary_a_detent),
   .rotary_b_detent(rotary_b_detent), .tri_toggle_a(tri_toggle_a), .tri_toggle_b(tri_toggle_b),
   .two_pos_switch(two_pos_switch), .momentary_switch(momentary_switch),
   .learn_start(learn_start), .assign_clr(assign_clr), .pulse_us(pulse_us),
   .learn_busy(learn_busy), .assign_five(assign_five), .assign_six(assign_six));

// ===== bench/test_servo_channel_shaping.sv
// Self-checking bench for the servo channel shaping block
`timescale 1ns/100ps
module test_servo_channel_shaping
   import servo_shaping_pkg::*;
;
   logic                core_clk = 0, rst = 1, cfg_rev_val = 0, cfg_trav_side = 0;
   logic                learn_input = 0, two_pos_switch = 0;
   logic signed [15:0]  chan_pct [6] = '{default: '0};
   logic signed [15:0]  rotary_a_pct = 0;
   logic        [3:0]   rotary_a_detent = 0;
   logic        [2:0]   cfg_sel = 0;
   logic signed [7:0]   cfg_off_val = 0;
   logic        [7:0]   cfg_trav_val = 0, stb = 0;
   logic        [15:0]  pulse_us [6];
   logic signed [15:0]  pos_pct [6];
   logic                learn_busy;
   source_t             assign_five, assign_six;
   int                  mismatches = 0, check_count = 0;
   always #5 core_clk = ~core_clk;
   servo_channel_shaping u_servo_channel_shaping (.core_clk(core_clk), .rst(rst),
      .chan_pct(chan_pct), .rotary_a_pct(rotary_a_pct), .rotary_b_pct(16'sh0000),
      .rotary_a_detent(rotary_a_detent), .rotary_b_detent(4'h0), .tri_toggle_a(2'h0),
      .tri_toggle_b(2'h0), .two_pos_switch(two_pos_switch), .momentary_switch(1'b0),
      .cfg_sel(cfg_sel), .cfg_rev_wr(stb[0]), .cfg_rev_val(cfg_rev_val), .cfg_rev_clr(stb[1]),
      .cfg_off_wr(stb[2]), .cfg_off_val(cfg_off_val), .cfg_off_clr(stb[3]),
      .cfg_trav_wr(stb[4]), .cfg_trav_side(cfg_trav_side), .cfg_trav_val(cfg_trav_val),
      .cfg_trav_clr(stb[5]), .learn_start(stb[6]), .learn_input(learn_input),
      .assign_clr(stb[7]), .pulse_us(pulse_us), .learn_busy(learn_busy),
      .assign_five(assign_five), .assign_six(assign_six));
   servo_bank_model u_servo_bank_model (.core_clk(core_clk), .pulse_us(pulse_us), .pos_pct(pos_pct));
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task strobe(input int k);
      stb[k] = 1;
      tick(1);
      stb = '0;
      tick(3);
   endtask
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task s_basic;
      chk("pulse0", 16'd1500, pulse_us[0]);
      chan_pct[0] = 50; chan_pct[4] = 100; tick(3);
      chk("pulse0", 16'd1750, pulse_us[0]);
      chk("pos0", 16'd50, pos_pct[0]);
      chk("pulse4", 16'd1500, pulse_us[4]);
      chk("pulse1", 16'd1500, pulse_us[1]);
   endtask
   task s_offset;
      chan_pct[0] = 0; cfg_off_val = 20; strobe(2);
      chk("pulse0", 16'd1600, pulse_us[0]);
      chan_pct[0] = -100; cfg_off_val = -125; strobe(2);
      chk("pulse0", 16'd750, pulse_us[0]);
      strobe(3);
      chk("pulse0", 16'd1000, pulse_us[0]);
   endtask
   task s_travel;
      cfg_trav_side = 0; cfg_trav_val = 50; strobe(4);
      chk("pulse0", 16'd1250, pulse_us[0]);
      cfg_rev_val = 1; strobe(0);
      chk("pulse0", 16'd2000, pulse_us[0]);
      cfg_trav_side = 1; cfg_trav_val = 150; strobe(4);
      chk("pulse0", 16'd2250, pulse_us[0]);
      strobe(5);
      chk("pulse0", 16'd2000, pulse_us[0]);
      strobe(1);
      chk("pulse0", 16'd1250, pulse_us[0]);
   endtask
   task s_learn;
      strobe(6);
      two_pos_switch = 1; tick(2);
      chk("assign5", 16'(src_two_pos), 16'(assign_five));
      chk("pulse4", 16'd2000, pulse_us[4]);
      two_pos_switch = 0; learn_input = 1; tick(2);
      chk("pulse4", 16'd1000, pulse_us[4]);
      stb[6] = 1; tick(1); stb = '0;
      rotary_a_detent = 2; tick(3);
      chk("busy", 16'd1, {15'd0, learn_busy});
      rotary_a_detent = 3; rotary_a_pct = 40; tick(3);
      chk("assign6", 16'(src_rotary_a), 16'(assign_six));
      chk("pulse5", 16'd1700, pulse_us[5]);
      learn_input = 0; strobe(7);
      chk("assign5", 16'(src_free), 16'(assign_five));
      chk("pulse4", 16'd1500, pulse_us[4]);
   endtask
   initial
   begin
      #200000;
      mismatches++;
      report_and_stop();
   end
   initial
   begin
      tick(5);
      rst = 0;
      tick(1);
      s_basic();
      s_offset();
      s_travel();
      s_learn();
      report_and_stop();
   end
endmodule // test_servo_channel_shaping
